// ---- hdl/asfl_alu.sv ----
`timescale 1ns/100ps
`default_nettype none

module asfl_alu
    import asfl_pkg::*;
(
    // operation and operands
    input  wire asfl_pkg::asfl_op_t op,
    input  wire logic [7:0]         opa,
    input  wire logic [7:0]         opb,
    input  wire logic [2:0]         bitsel,
    input  wire logic [4:0]         flags_in,
    // outputs
    output logic [7:0]              result,
    output logic [4:0]              flags_out
);

    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] addend;
    logic       sub;

    // combinational datapath and flag update
    always_comb begin
        sub       = (op == ASFL_OP_LITERAL_MINUS_ACCUMULATOR_OP) || (op == ASFL_OP_FILE_MINUS_ACCUMULATOR_OP);
        // inverted operand plus carry in: one adder yields carries and overflow sign
        addend    = sub ? ~opb : opb;                       // see RULE7
        sum       = {1'b0, opa} + {1'b0, addend} + {8'h00, sub};
        low       = {1'b0, opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub};
        result    = 8'h00;
        flags_out = flags_in;                       // see RULE15
        case (op)
            ASFL_OP_ADD_ACCUMULATOR_FILE_OP, ASFL_OP_ADD_LITERAL_OP, ASFL_OP_LITERAL_MINUS_ACCUMULATOR_OP, ASFL_OP_FILE_MINUS_ACCUMULATOR_OP: begin
                result             = sum[7:0];
                flags_out[FLAG_C]  = sum[8];        // see RULE5 see RULE6
                flags_out[FLAG_DC] = low[4];        // see RULE4 see RULE6
                flags_out[FLAG_OV] = (opa[7] == addend[7]) && (sum[7] != opa[7]); // see RULE2
                flags_out[FLAG_Z]  = (sum[7:0] == 8'h00); // see RULE3
                flags_out[FLAG_N]  = sum[7];        // see RULE1
            end
            ASFL_OP_AND, ASFL_OP_IOR, ASFL_OP_XOR: begin
                result = (op == ASFL_OP_AND) ? (opa & opb) :
                         (op == ASFL_OP_IOR) ? (opa | opb) : (opa ^ opb);
                flags_out[FLAG_Z] = (result == 8'h00); // see RULE3
                flags_out[FLAG_N] = result[7];      // see RULE1
            end
            ASFL_OP_CLR: begin
                flags_out[FLAG_Z] = 1'b1;           // see RULE11
            end
            ASFL_OP_RRF: begin
                result             = {flags_in[FLAG_C], opa[7:1]};
                flags_out[FLAG_C]  = opa[0];        // see RULE9
                flags_out[FLAG_DC] = opa[4];        // see RULE8
                flags_out[FLAG_Z]  = (result == 8'h00);
                flags_out[FLAG_N]  = result[7];
            end
            ASFL_OP_RLF: begin
                result             = {opa[6:0], flags_in[FLAG_C]};
                flags_out[FLAG_C]  = opa[7];        // see RULE9
                flags_out[FLAG_DC] = opa[3];        // see RULE8
                flags_out[FLAG_Z]  = (result == 8'h00);
                flags_out[FLAG_N]  = result[7];
            end
            ASFL_OP_BCLR:  result = opa & ~(8'h01 << bitsel); // see RULE12
            ASFL_OP_BSET:  result = opa | (8'h01 << bitsel);  // see RULE12
            ASFL_OP_SWAP:  result = {opa[3:0], opa[7:4]};     // see RULE12
            ASFL_OP_COPY,
            ASFL_OP_STORE: result = opa;                      // see RULE12
            default:       result = 8'h00;
        endcase
    end

endmodule

`default_nettype wire

// ---- hdl/asfl_top.sv ----
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// RULE1 - negative flag bit 4 follows result most significant bit
// RULE2 - overflow flag bit 3 set when signed result wraps the sign
// RULE3 - zero flag bit 2 set when arithmetic or logic result is zero
// RULE4 - add/subtract ops load half carry bit 1 from low nibble carry
// RULE5 - add/subtract ops load carry bit 0 from most significant carry
// RULE6 - in subtraction carry flags mean no borrow when set
// RULE7 - subtraction adds the two's complement of the second operand
// RULE8 - rotates load half carry from source bit 4 or bit 3
// RULE9 - rotates load carry from source high or low bit
// RULE10 - flag register as destination of flag-affecting op takes only flags
// RULE11 - clearing the flag register sets zero, keeps other flags
// RULE12 - bit clear, bit set, swap, copy and store change no flag
// RULE13 - bits 7 to 5 of flag register read zero, ignore writes
// RULE14 - flag register usable as ordinary source and destination
// RULE15 - flags not affected by an op keep their previous value

module asfl_top
    import asfl_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // flag and result outputs
    output logic [7:0]       flags_out,
    output logic [7:0]       result_out
);

    import asfl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [4:0]  flags_q;
    logic [7:0]  opa_q;
    logic [7:0]  opb_q;
    logic [7:0]  result_q;
    logic [7:0]  res_d;
    logic [4:0]  fl_d;
    logic        access;
    logic        commit;
    logic        wr;
    logic        run;
    logic        dest_flags;
    logic        mapped;
    logic [7:0]  src_a;
    asfl_op_t    op;

    // first access edge launches the answer, writes land when ready is seen
    assign access = psel && penable && !pready;
    assign commit = psel && penable && pready;
    assign wr     = commit && pwrite;
    assign mapped = (paddr == REG_FLAGS) || (paddr == REG_OPA) || (paddr == REG_OPB)
                 || (paddr == REG_CTRL) || (paddr == REG_RESULT);
    assign run        = wr && (paddr == REG_CTRL) && pstrb[0];
    assign op         = asfl_op_t'(pwdata[CTRL_OP_LSB +: CTRL_OP_W]);
    assign dest_flags = pwdata[CTRL_DEST];

    // flag register readable as source operand
    assign src_a = pwdata[CTRL_CIN] ? {3'h0, flags_q} : opa_q;  // see RULE14

    ////////////////////////////////////////////////////////////////////////
    // datapath

    asfl_alu u_alu (
        .op        (op),
        .opa       (src_a),
        .opb       (opb_q),
        .bitsel    (pwdata[CTRL_BIT_LSB +: CTRL_BIT_W]),
        .flags_in  (flags_q),
        .result    (res_d),
        .flags_out (fl_d)
    );

    // flag register update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= FLAG_RESET;
        end else if (wr && paddr == REG_FLAGS && pstrb[0]) begin
            flags_q <= pwdata[FLAG_W-1:0];                 // see RULE13 see RULE14
        end else if (run) begin
            if (dest_flags && fl_d == flags_q && (op == ASFL_OP_BCLR || op == ASFL_OP_BSET
                || op == ASFL_OP_SWAP || op == ASFL_OP_COPY || op == ASFL_OP_STORE)) begin
                flags_q <= res_d[FLAG_W-1:0];              // see RULE12 see RULE14
            end else begin
                flags_q <= fl_d;                           // see RULE10 see RULE15
            end
        end
    end

    // operand registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opa_q <= 8'h00;
            opb_q <= 8'h00;
        end else if (wr && pstrb[0]) begin
            if (paddr == REG_OPA) opa_q <= pwdata[7:0];
            if (paddr == REG_OPB) opb_q <= pwdata[7:0];
        end
    end

    // result register, skipped when flags are destination
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 8'h00;
        end else if (run && !dest_flags) begin
            result_q <= res_d;                             // see RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer, one wait state then a one-cycle ready pulse

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access && !mapped;
            prdata  <= 32'h0000_0000;
            if (access && !pwrite) begin
                case (paddr)
                    REG_FLAGS:  prdata <= {27'h0, flags_q};  // see RULE13
                    REG_OPA:    prdata <= {24'h0, opa_q};
                    REG_OPB:    prdata <= {24'h0, opb_q};
                    REG_RESULT: prdata <= {24'h0, result_q};
                    default:    prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // registered mirrors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_out  <= 8'h00;
            result_out <= 8'h00;
        end else begin
            flags_out  <= {3'h0, flags_q};
            result_out <= result_q;
        end
    end

endmodule

`default_nettype wire

// ---- include/asfl_pkg.sv ----
package asfl_pkg;

    // flag register field positions
    localparam int FLAG_C   = 0;
    localparam int FLAG_DC  = 1;
    localparam int FLAG_Z   = 2;
    localparam int FLAG_OV  = 3;
    localparam int FLAG_N   = 4;
    localparam int FLAG_W   = 5;
    localparam logic [4:0] FLAG_RESET = 5'h00;

    // apb register byte offsets
    localparam logic [11:0] REG_FLAGS   = 12'h000;
    localparam logic [11:0] REG_OPA     = 12'h004;
    localparam logic [11:0] REG_OPB     = 12'h008;
    localparam logic [11:0] REG_CTRL    = 12'h00C;
    localparam logic [11:0] REG_RESULT  = 12'h010;

    // control register field layout
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_OP_W    = 5;
    localparam int CTRL_DEST    = 8;
    localparam int CTRL_CIN     = 9;
    localparam int CTRL_BIT_LSB = 12;
    localparam int CTRL_BIT_W   = 3;

    // operation codes
    typedef enum logic [4:0] {
        ASFL_OP_NONE     = 5'h00,
        ASFL_OP_ADD_ACCUMULATOR_FILE_OP    = 5'h01,
        ASFL_OP_ADD_LITERAL_OP    = 5'h02,
        ASFL_OP_LITERAL_MINUS_ACCUMULATOR_OP    = 5'h03,
        ASFL_OP_FILE_MINUS_ACCUMULATOR_OP    = 5'h04,
        ASFL_OP_AND      = 5'h05,
        ASFL_OP_IOR      = 5'h06,
        ASFL_OP_XOR      = 5'h07,
        ASFL_OP_CLR      = 5'h08,
        ASFL_OP_RRF      = 5'h09,
        ASFL_OP_RLF      = 5'h0A,
        ASFL_OP_BCLR     = 5'h0B,
        ASFL_OP_BSET     = 5'h0C,
        ASFL_OP_SWAP     = 5'h0D,
        ASFL_OP_COPY     = 5'h0E,
        ASFL_OP_STORE    = 5'h0F
    } asfl_op_t;

endpackage

// ---- tb/alu_status_flag_logic_test.sv ----
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the flag block over apb
module alu_status_flag_logic_test;
    import asfl_pkg::*;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [7:0]  flags_out, result_out;
    int          miscompares = 0, num_checks = 0, cycles = 0;
    ////////////////////////////////
    // design, core model and full byte strobes
    asfl_top uut (.*);
    asfl_core_model core (.*);
    assign pstrb = 4'hF;
    // 25 ns clock
    always #12.5 pclk = ~pclk;
    // cut a hung run short
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) complete_run(1);
    end
    // compare one byte and count
    task automatic chk(input string what, input logic [7:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // preset flags, load operands, issue one operation, read result and flags back
    task automatic run(input logic [7:0] f, input logic [31:0] ctl, input logic [7:0] a, b,
                       input logic [8:0] er, input logic [7:0] ef);
        core.xfer(1'h1, REG_FLAGS, {24'h0, f});
        core.xfer(1'h1, REG_OPA, {24'h0, a});
        core.xfer(1'h1, REG_OPB, {24'h0, b});
        core.xfer(1'h1, REG_CTRL, ctl);
        core.xfer(1'h0, REG_RESULT, 32'h0);
        if (!er[8]) chk("result", er[7:0], core.rdat[7:0]);
        if (!er[8]) chk("result copy", er[7:0], result_out);
        core.xfer(1'h0, REG_FLAGS, 32'h0);
        chk("flags", ef, core.rdat[7:0]);
        chk("flag copy", ef, flags_out);
    endtask
    // counts and verdict
    task automatic complete_run(input int hung);
        miscompares += hung;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // arithmetic, logic and rotate flag updates
    task automatic t_compute;
        run(8'h00, 32'h01, 8'h88, 8'h88, 9'h010, 8'h0B);
        run(8'h00, 32'h02, 8'h7F, 8'h01, 9'h080, 8'h1A);
        run(8'h00, 32'h04, 8'h05, 8'h05, 9'h000, 8'h07);
        run(8'h1F, 32'h03, 8'h00, 8'h01, 9'h0FF, 8'h10);
        run(8'h00, 32'h04, 8'h80, 8'h01, 9'h07F, 8'h09);
        run(8'h1F, 32'h05, 8'hF0, 8'h0F, 9'h000, 8'h0F);
        run(8'h00, 32'h06, 8'h80, 8'h01, 9'h081, 8'h10);
        run(8'h03, 32'h07, 8'h5A, 8'h5A, 9'h000, 8'h07);
        run(8'h08, 32'h09, 8'h11, 8'h00, 9'h008, 8'h0B);
        run(8'h01, 32'h0A, 8'h88, 8'h00, 9'h011, 8'h03);
    endtask
    // flag register as destination, source and plain register
    task automatic t_flag_reg;
        run(8'h00, 32'h01, 8'h10, 8'h20, 9'h030, 8'h00);
        run(8'h00, 32'h101, 8'h01, 8'h02, 9'h030, 8'h00);
        run(8'h1B, 32'h108, 8'h55, 8'h00, 9'h030, 8'h1F);
        for (int i = 11; i <= 15; i++)
            run(8'h15, 32'(i), 8'h00, 8'h00, 9'h100, 8'h15);
        run(8'h00, 32'h230C, 8'h00, 8'h00, 9'h100, 8'h04);
        run(8'hFF, 32'h00, 8'h00, 8'h00, 9'h100, 8'h1F);
        core.xfer(1'h0, 12'h020, 32'h0);
        chk("unmapped error", 8'h01, {7'h0, core.rerr});
        chk("unmapped data", 8'h00, core.rdat[7:0]);
        core.xfer(1'h0, REG_CTRL, 32'h0);
        chk("control read", 8'h00, core.rdat[7:0]);
    endtask
    // reset, scenarios, verdict
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        t_compute();
        t_flag_reg();
        complete_run(0);
    end
endmodule
`default_nettype wire

// ---- tb/asfl_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// apb master standing in for the core's execution logic
module asfl_core_model (
    // clock and apb master side
    input  wire logic        pclk,
    output logic             psel = 1'h0,
    output logic             penable = 1'h0,
    output logic             pwrite = 1'h0,
    output logic [11:0]      paddr = 12'h000,
    output logic [31:0]      pwdata = 32'h0,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rdat;
    logic        rerr;
    ////////////////////////////////
    // one transfer: setup, access held until pready, then release
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk iff pready === 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        pwdata  <= ~d;
    endtask
endmodule
`default_nettype wire

// ---- tb/asfl_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the flag block
module asfl_checker (
    // clock, reset and apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // flag and result copies
    input wire logic [7:0]  flags_out,
    input wire logic [7:0]  result_out
);
    import asfl_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decoded offset and answered read
    wire mapped = paddr inside {REG_FLAGS, REG_OPA, REG_OPB, REG_CTRL, REG_RESULT};
    wire rd     = pready && !pwrite;
    ////////////////////////////////
    a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("no ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
    a_mapped_ok: assert property (pready && mapped |-> !pslverr) else $error("mapped refused");
    a_upper_zero: assert property (flags_out[7:5] == 3'h0) else $error("upper bits");
    a_flags_read:
        assert property (rd && paddr == REG_FLAGS |-> prdata == {24'h0, flags_out})
        else $error("flag read");
    a_result_read:
        assert property (rd && paddr == REG_RESULT |-> prdata == {24'h0, result_out})
        else $error("result read");
    a_flags_hold:
        assert property (!pwrite [*4] |=> $stable(flags_out)) else $error("flags moved");
    // main scenarios reached
    c_refused: cover property (pready && pslverr);
    c_zero_flag: cover property (flags_out[FLAG_Z]);
    c_both_carries: cover property (flags_out[FLAG_DC] && flags_out[FLAG_C]);
endmodule
bind asfl_top asfl_checker chk (.*);
`default_nettype wire
